// File: rtl/serial_audio_in.v
// Serial audio input port receiver
`timescale 1ns/1ps
module serial_audio_in (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        clk_en,
  input  wire [2:0]  input_format,
  input  wire        input_bitclk_edge_select,
  input  wire        input_wordclk_polarity,
  input  wire        bit_clock_in,
  input  wire        word_clock_in,
  input  wire        serial_data_input_zero,
  output reg  [23:0] sample_data,
  output reg  [2:0]  sample_channel,
  output reg         sample_valid,
  output reg         format_error
);
`include "serial_audio_in_consts.vh"

  // ------------------------------------------------------------
  // Format helpers
  // ------------------------------------------------------------
  // Right-justified codes form one range, decoded in several places
  function is_right;
    input [2:0] f;
    begin
      is_right = (f >= `FMT_RJ24) && (f <= `FMT_RJ16);
    end
  endfunction

  // Slot index of the first word bit; stereo and multiplex lose one bit
  function [4:0] word_first;
    input [2:0] f;
    begin
      case (f)
        `FMT_LEFT: word_first = 5'h00;
        `FMT_RJ24: word_first = `RJ24_LEAD;
        `FMT_RJ20: word_first = `RJ20_LEAD;
        `FMT_RJ18: word_first = `RJ18_LEAD;
        `FMT_RJ16: word_first = `RJ16_LEAD;
        default:   word_first = 5'h01;
      endcase
    end
  endfunction

  // Right-justified words run to the slot end, the others last 24 bits
  function in_word;
    input [2:0] f;
    input [4:0] idx;
    begin
      if (is_right(f))
        in_word = (idx >= word_first(f));
      else
        in_word = (idx >= word_first(f)) && (idx < word_first(f) + `WORD_BITS);
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg [1:0]  bck_s_q;
  reg [1:0]  wck_s_q;
  reg [1:0]  dat_s_q;
  reg        bck_prev_q;
  reg        wck_cap_q;
  reg [23:0] shift_q;
  reg [4:0]  bit_q;
  reg [2:0]  ch_q;
  reg        run_q;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      bck_s_q <= 2'h0;
    end else if (clk_en) begin
      bck_s_q <= {bck_s_q[0], bit_clock_in};
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      wck_s_q <= 2'h0;
    end else if (clk_en) begin
      wck_s_q <= {wck_s_q[0], word_clock_in};
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      dat_s_q <= 2'h0;
    end else if (clk_en) begin
      dat_s_q <= {dat_s_q[0], serial_data_input_zero};
    end
  end

  // Idle bit clock is low, so reset to low gives no false edge
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      bck_prev_q <= 1'b0;
    end else if (clk_en) begin
      bck_prev_q <= bck_s_q[1];
    end
  end

  // ------------------------------------------------------------
  // Edge and boundary decode
  // ------------------------------------------------------------
  wire        bck_now     = bck_s_q[1];
  wire        wck_now     = wck_s_q[1];
  wire        dat_now     = dat_s_q[1];
  wire        rise        = bck_now & ~bck_prev_q;
  wire        fall        = ~bck_now & bck_prev_q;
  wire        fmt_ok      = (input_format != `FMT_RSVD);
  wire        is_tdm      = (input_format == `FMT_TDM);
  wire        is_just     = (input_format == `FMT_LEFT) || is_right(input_format);
  // Outside multiplex, data changes on the selected edge, so it is stable at the other; multiplex always captures on the rise
  wire        cap_edge    = is_tdm ? rise : (input_bitclk_edge_select ? fall : rise);
  wire        take        = cap_edge & fmt_ok;
  // First-channel level: justified formats take the inverse of the stereo level, high first when polarity is 0
  wire        first_lvl   = is_just ? ~input_wordclk_polarity : input_wordclk_polarity;
  // Multiplex frame starts on a falling word clock, pulse or square wave alike
  wire        tdm_start   = wck_cap_q & ~wck_now;
  wire        chan_change = (wck_now != wck_cap_q);
  wire        boundary    = is_tdm ? tdm_start : chan_change;
  wire        first_in    = in_word(input_format, 5'h00);
  wire        idx_in      = in_word(input_format, bit_q);
  wire [23:0] shift_next  = idx_in ? {shift_q[22:0], dat_now} : shift_q;
  wire        slot_end    = run_q & ~boundary & (bit_q == `SLOT_BITS);
  wire        tdm_last    = is_tdm & (ch_q == `LAST_CH);
  wire [2:0]  start_ch    = (is_tdm || wck_now == first_lvl) ? 3'h0 : 3'h1;

  // ------------------------------------------------------------
  // Slot control
  // ------------------------------------------------------------
  // Word clock is taken at the capture edge to stay aligned with data
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      wck_cap_q <= 1'b0;
    end else if (clk_en && take) begin
      wck_cap_q <= wck_now;
    end
  end

  // Multiplex slots after the last channel wait for the next frame
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      run_q <= 1'b0;
    end else if (clk_en && take) begin
      if (boundary)
        run_q <= 1'b1;
      else if (slot_end && tdm_last)
        run_q <= 1'b0;
    end
  end

  // The boundary bit itself is slot index zero
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      bit_q <= 5'h00;
    end else if (clk_en && take) begin
      if (boundary)
        bit_q <= 5'h01;
      else if (slot_end)
        bit_q <= 5'h00;
      else if (run_q)
        bit_q <= bit_q + 5'h01;
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      ch_q <= 3'h0;
    end else if (clk_en && take) begin
      if (boundary)
        ch_q <= start_ch;
      else if (slot_end && is_tdm && !tdm_last)
        ch_q <= ch_q + 3'h1;
    end
  end

  // Shorter right-justified words end up in the low bits
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      shift_q <= 24'h000000;
    end else if (clk_en && take) begin
      if (boundary)
        shift_q <= first_in ? {23'h000000, dat_now} : 24'h000000;
      else if (slot_end)
        shift_q <= 24'h000000;
      else if (run_q)
        shift_q <= shift_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Last slot bit may still be a word bit, so hand out the next value
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      sample_data <= 24'h000000;
    end else if (clk_en && take && slot_end) begin
      sample_data <= shift_next;
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      sample_channel <= 3'h0;
    end else if (clk_en && take && slot_end) begin
      sample_channel <= ch_q;
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      sample_valid <= 1'b0;
    end else if (clk_en) begin
      sample_valid <= take & slot_end;
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      format_error <= 1'b0;
    end else if (clk_en) begin
      format_error <= ~fmt_ok;
    end
  end

  // ------------------------------------------------------------
  // Notes
  // ------------------------------------------------------------
  // A boundary that arrives before slot end drops the half-built word;
  // a shorter slot cannot be told apart from a broken link.
  // Bit clock needs at least four system clocks per half period.
endmodule

// File: rtl/serial_audio_in_consts.vh
// Constants for the serial audio input port
// What this block does
// - Bit-clock edge select picks the edge data changes on; capture uses the other, except multiplex, which always captures on the rising edge.
// - Format field: 000 stereo, 001 left, 010 multiplex, 011-110 right; 111 reserved.
// - Multiplex channels zero to three in first half, four to seven second half.
// - Left and right justified invert the stereo first-channel level: word clock high first with polarity 0, low first with polarity 1.
// - Multiplex accepts a single word-clock pulse as frame start.
`ifndef SERIAL_AUDIO_IN_CONSTS_VH
`define SERIAL_AUDIO_IN_CONSTS_VH
`define FMT_STEREO   3'h0
`define FMT_LEFT     3'h1
`define FMT_TDM      3'h2
`define FMT_RJ24     3'h3
`define FMT_RJ20     3'h4
`define FMT_RJ18     3'h5
`define FMT_RJ16     3'h6
`define FMT_RSVD     3'h7
`define SAMPLE_W     24
`define SLOT_BITS    5'h1f
`define WORD_BITS    5'h18
`define RJ24_LEAD    5'h08
`define RJ20_LEAD    5'h0c
`define RJ18_LEAD    5'h0e
`define RJ16_LEAD    5'h10
`define LAST_CH      3'h7
`define NUM_CH       8
`endif

// File: sim/audio_src.sv
// Serial audio source model
`timescale 1ns/1ps
module audio_src;
  logic bclk = 1'b0;
  logic wclk = 1'b1;
  logic sdata = 1'b0;
  task automatic frame(input logic [2:0] f, input logic e, l, input logic [23:0] b);
    int n, o, j;
    logic [23:0] w;
    n = f == 3'h4 ? 20 : f == 3'h5 ? 18 : f == 3'h6 ? 16 : 24;
    o = f == 3'h1 ? 0 : f > 3'h2 ? 32 - n : 1;
    // Lead bit gives the word clock an edge to find
    for (int i = -1; i < (f == 3'h2 ? 256 : 64); i++) begin
      j = i & 31;
      w = b + 24'(i / 32);
      bclk = e;
      wclk = f == 3'h2 ? i != 0 : l ^ (i < 0 || i > 31);
      sdata = j >= o && j < o + n ? w[n - 1 - j + o] : i[0];
      #80 bclk = ~e;
      #80;
    end
    bclk = e;
    sdata = ~sdata;
  endtask
endmodule

// File: sim/serial_audio_in_asserts.sv
// Checker for the serial audio input port
`timescale 1ns/1ps
module serial_audio_in_asserts (
  input logic       sys_clk,
  input logic       reset_n,
  input logic [2:0] input_format,
  input logic [2:0] sample_channel,
  input logic       sample_valid,
  input logic       format_error
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rsvd; input_format == 3'h7 ##1 input_format == 3'h7; endsequence
  property p_on; s_rsvd |-> format_error; endproperty
  a_on: assert property (p_on) else $error("flag low");
  property p_off; (input_format != 3'h7) [*2] |-> !format_error; endproperty
  a_off: assert property (p_off) else $error("flag high");
  property p_mute; format_error |-> !sample_valid; endproperty
  a_mute: assert property (p_mute) else $error("word in reserved");
  property p_two; sample_valid && input_format != 3'h2 |-> sample_channel < 3'h2; endproperty
  a_two: assert property (p_two) else $error("bad channel");
  property p_gap; sample_valid |=> !sample_valid [*8]; endproperty
  a_gap: assert property (p_gap) else $error("words too close");
endmodule
bind serial_audio_in serial_audio_in_asserts serial_audio_in_asserts_i (.*);

// File: sim/serial_audio_in_bench.sv
// Bench for the serial audio input port
`timescale 1ns/1ps
module serial_audio_in_bench;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  input_format = 3'h0;
  logic        input_bitclk_edge_select = 1'b0;
  logic        input_wordclk_polarity = 1'b0;
  logic [23:0] sample_data;
  logic [2:0]  sample_channel;
  logic        sample_valid, format_error;
  int          fails = 0;
  int          check_count = 0;
  logic [26:0] got[$];
  audio_src audio_src_i();
  serial_audio_in serial_audio_in_i (.*, .clk_en(1'b1), .bit_clock_in(audio_src_i.bclk),
    .word_clock_in(audio_src_i.wclk), .serial_data_input_zero(audio_src_i.sdata));
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sample_valid === 1'b1) got.push_back({sample_channel, sample_data});
  task automatic check(input logic [26:0] g, x);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run(input logic [2:0] f, input logic e, l);
    logic [23:0] m;
    @(posedge sys_clk) #2;
    input_format = f;
    input_bitclk_edge_select = e;
    input_wordclk_polarity = l;
    got.delete();
    audio_src_i.frame(f, e, f == 3'h0 ? l : ~l, 24'ha5c3e1);
    repeat (10) @(posedge sys_clk);
    m = 24'hffffff >> (f > 3'h3 ? 2 * f - 4 : 0);
    check(27'(got.size()), f == 3'h7 ? 27'h0 : f == 3'h2 ? 27'h8 : 27'h2);
    foreach (got[k]) check(got[k], {k[2:0], (24'ha5c3e1 + 24'(k)) & m});
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    #2 reset_n = 1'b1;
    for (int f = 0; f < 8; f++) run(3'(f), 1'b0, f[0]);
    run(3'h0, 1'b1, 1'b1);
    give_verdict();
  end
  // Nine frames need well under this
  initial begin
    #1ms;
    fails++;
    give_verdict();
  end
endmodule
